// file: design/dsac_pkg.sv
// Constants and carrier types of the data space access checker
package dsac_pkg;

    localparam int DSAC_NUM_WREGS = 16;
    localparam int DSAC_RAM_WORDS = 256;
    localparam int DSAC_RAM_AW = 8;

    localparam logic [15:0] DSAC_DEFAULT_WORKING_REG_RESET = 16'h0000;
    localparam logic [15:0] DSAC_SP_RESET = 16'h0800;
    localparam logic [15:0] DSAC_STACK_FLOOR = 16'h0800;
    localparam logic [15:0] DSAC_NEAR_MASK = 16'h1FFF;
    localparam logic [15:0] DSAC_STACK_LIMIT_REG_OFS = 16'h0020;
    localparam logic [15:0] DSAC_STACK_LIMIT_REG_MASK = 16'hFFFE;
    localparam logic [15:0] DSAC_STEP_BYTE = 16'h0001;
    localparam logic [15:0] DSAC_STEP_WORD = 16'h0002;
    localparam logic [15:0] DSAC_ZERO_WORD = 16'h0000;
    localparam logic [7:0] DSAC_ZERO_BYTE = 8'h00;

    // Implemented RAM and the Y block inside it
    localparam logic [15:0] DSAC_RAM_BASE = 16'h0800;
    localparam logic [15:0] DSAC_RAM_END = 16'h09FF;
    localparam logic [15:0] DSAC_Y_BASE = 16'h0900;
    localparam logic [15:0] DSAC_Y_END = 16'h09FF;

    // Protected RAM segments
    localparam logic [15:0] DSAC_BOOT_SECURE_RAM_LO = 16'h0800;
    localparam logic [15:0] DSAC_BOOT_SECURE_RAM_HI = 16'h083F;
    localparam logic [15:0] DSAC_SECURE_SEGMENT_RAM_LO = 16'h0840;
    localparam logic [15:0] DSAC_SECURE_SEGMENT_RAM_HI = 16'h087F;

    localparam logic [3:0] DSAC_SP_IDX = 4'hF;
    localparam logic [3:0] DSAC_MACX_IDX = 4'h8;
    localparam logic [3:0] DSAC_MACY_IDX = 4'hA;

    // Data space offsets of working_reg_0 .. stack_pointer_reg
    localparam logic [15:0] DSAC_DEFAULT_WORKING_REG_OFS [DSAC_NUM_WREGS] = '{
        16'h0000, 16'h0002, 16'h0004, 16'h0006, 16'h8000, 16'h000A, 16'h000C, 16'h000E,
        16'h0010, 16'h0012, 16'h0014, 16'h0016, 16'h0018, 16'h001A, 16'h001C, 16'h001E};

    typedef enum logic [9:0] {
        DSAC_OP_NONE = 10'h001,
        DSAC_OP_READ = 10'h002,
        DSAC_OP_WRITE = 10'h004,
        DSAC_OP_PUSH = 10'h008,
        DSAC_OP_POP = 10'h010,
        DSAC_OP_CALL_PUSH = 10'h020,
        DSAC_OP_EXC_PUSH = 10'h040,
        DSAC_OP_SIGN_EXT = 10'h080,
        DSAC_OP_ZERO_EXT = 10'h100,
        DSAC_OP_MAC_FETCH = 10'h200
    } dsac_op_t;

    typedef enum logic [2:0] {
        DSAC_AM_INDIRECT = 3'h1,
        DSAC_AM_NEAR = 3'h2,
        DSAC_AM_ABS = 3'h4
    } dsac_amode_t;

    typedef struct packed {
        logic valid;
        dsac_op_t op;
        dsac_amode_t amode;
        logic byte_op;
        logic post_inc;
        logic [3:0] ptr;
        logic [3:0] dst;
        logic [15:0] abs_addr;
        logic [15:0] wdata;
        logic [15:0] pc_high;
        logic [7:0] status_low_byte;
        logic mac_x_sel;
        logic mac_y_sel;
        logic exec_boot;
        logic exec_secure;
    } dsac_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] x_data;
        logic [15:0] y_data;
        logic addr_err;
        logic stack_err;
        logic access_denied;
    } dsac_rsp_t;

    typedef struct packed {
        logic [DSAC_NUM_WREGS-1:0][15:0] default_working_reg;
        dsac_rsp_t rsp;
    } dsac_state_t;

    localparam dsac_state_t DSAC_STATE_RESET = '{
        default_working_reg: {DSAC_SP_RESET, {(DSAC_NUM_WREGS-1){DSAC_DEFAULT_WORKING_REG_RESET}}},
        rsp: '0};

endpackage

// file: design/dsac_top.sv
// Data space access checker: byte lanes, alignment, stack checks and secure RAM
`timescale 1ns/100ps
module dsac_top (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire dsac_pkg::dsac_req_t req,
    input wire logic boot_secure_ram_en,
    input wire logic secure_segment_ram_en,
    output dsac_pkg::dsac_rsp_t rsp
);

    dsac_pkg::dsac_state_t state_reg;
    dsac_pkg::dsac_state_t state_next;
    logic [15:0] stack_limit_reg;
    logic [15:0] stack_limit_next;
    logic stack_limit_we;
    logic [15:0] ram_mem [dsac_pkg::DSAC_RAM_WORDS];
    logic [1:0] ram_we;
    logic [dsac_pkg::DSAC_RAM_AW-1:0] ram_idx;
    logic [15:0] ram_wdata;

    logic [15:0] effective_address;
    logic [15:0] ea_y;
    logic [15:0] rd_word;
    logic [7:0] rd_byte;
    logic [15:0] wr_data;
    logic [1:0] wr_lanes;
    logic [15:0] step;
    logic [15:0] sp_cur;
    logic [15:0] ptr_val;
    logic [15:0] dst_val;
    logic [4:0] wr_hit;
    logic mem_op;
    logic uses_sp;
    logic misalign;
    logic denied;
    logic stack_fault;

    function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                      input logic [15:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    // Shared word decode of the working registers
    function automatic logic [4:0] default_working_reg_lookup(input logic [15:0] a);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < dsac_pkg::DSAC_NUM_WREGS; i++)
        begin
            if ({a[15:1], 1'b0} == dsac_pkg::DSAC_DEFAULT_WORKING_REG_OFS[i])
                r = {1'b1, 4'(i)};
        end
        return r;
    endfunction

    function automatic logic [dsac_pkg::DSAC_RAM_AW-1:0] ram_index(input logic [15:0] a);
        logic [15:0] off;
        off = a - dsac_pkg::DSAC_RAM_BASE;
        return off[dsac_pkg::DSAC_RAM_AW:1];
    endfunction

    // Whole word at an address; unimplemented space reads zero
    function automatic logic [15:0] word_at(input logic [15:0] a);
        logic [4:0] hit;
        hit = default_working_reg_lookup(a);
        if (hit[4])
            return state_reg.default_working_reg[hit[3:0]];
        else if ({a[15:1], 1'b0} == dsac_pkg::DSAC_STACK_LIMIT_REG_OFS)
            return stack_limit_reg & dsac_pkg::DSAC_STACK_LIMIT_REG_MASK;
        else if (in_range(a, dsac_pkg::DSAC_RAM_BASE, dsac_pkg::DSAC_RAM_END))
            return ram_mem[ram_index(a)];
        else
            return dsac_pkg::DSAC_ZERO_WORD;
    endfunction

    function automatic logic sec_block(input logic [15:0] a, input logic eb,
                                       input logic es);
        return (boot_secure_ram_en && !eb &&
                in_range(a, dsac_pkg::DSAC_BOOT_SECURE_RAM_LO, dsac_pkg::DSAC_BOOT_SECURE_RAM_HI)) ||
               (secure_segment_ram_en && !es &&
                in_range(a, dsac_pkg::DSAC_SECURE_SEGMENT_RAM_LO, dsac_pkg::DSAC_SECURE_SEGMENT_RAM_HI));
    endfunction

    assign sp_cur = state_reg.default_working_reg[dsac_pkg::DSAC_SP_IDX];
    assign ptr_val = state_reg.default_working_reg[req.ptr];
    assign dst_val = state_reg.default_working_reg[req.dst];

    always_comb
    begin
        state_next = state_reg;
        state_next.rsp = '0;
        stack_limit_next = stack_limit_reg;
        stack_limit_we = 1'b0;
        ram_we = 2'b00;
        ram_idx = '0;
        ram_wdata = dsac_pkg::DSAC_ZERO_WORD;
        wr_data = dsac_pkg::DSAC_ZERO_WORD;
        wr_lanes = 2'b00;
        wr_hit = 5'h00;
        ea_y = dsac_pkg::DSAC_ZERO_WORD;
        uses_sp = 1'b0;
        mem_op = 1'b1;
        step = req.byte_op ? dsac_pkg::DSAC_STEP_BYTE : dsac_pkg::DSAC_STEP_WORD;
        // Address generation per operation
        case (req.op)
            dsac_pkg::DSAC_OP_READ, dsac_pkg::DSAC_OP_WRITE:
            begin
                case (req.amode)
                    dsac_pkg::DSAC_AM_NEAR:
                        effective_address = req.abs_addr & dsac_pkg::DSAC_NEAR_MASK;
                    dsac_pkg::DSAC_AM_ABS:
                        effective_address = req.abs_addr;
                    default:
                        effective_address = ptr_val;
                endcase
                uses_sp = (req.amode == dsac_pkg::DSAC_AM_INDIRECT) &&
                          (req.ptr == dsac_pkg::DSAC_SP_IDX);
            end
            dsac_pkg::DSAC_OP_PUSH, dsac_pkg::DSAC_OP_CALL_PUSH, dsac_pkg::DSAC_OP_EXC_PUSH:
            begin
                effective_address = sp_cur;
                uses_sp = 1'b1;
            end
            dsac_pkg::DSAC_OP_POP:
            begin
                effective_address = sp_cur - dsac_pkg::DSAC_STEP_WORD;
                uses_sp = 1'b1;
            end
            dsac_pkg::DSAC_OP_MAC_FETCH:
            begin
                effective_address = state_reg.default_working_reg[dsac_pkg::DSAC_MACX_IDX | 4'(req.mac_x_sel)];
                ea_y = state_reg.default_working_reg[dsac_pkg::DSAC_MACY_IDX | 4'(req.mac_y_sel)];
            end
            default:
            begin
                effective_address = dsac_pkg::DSAC_ZERO_WORD;
                mem_op = 1'b0;
            end
        endcase
        // Word accesses must be even; byte reads and writes may be odd
        misalign = mem_op && (effective_address[0] || ea_y[0]) &&
                   !(req.byte_op && (req.op == dsac_pkg::DSAC_OP_READ ||
                                     req.op == dsac_pkg::DSAC_OP_WRITE));
        denied = mem_op && sec_block(effective_address, req.exec_boot, req.exec_secure);
        stack_fault = uses_sp && (effective_address > (stack_limit_reg &
                                  dsac_pkg::DSAC_STACK_LIMIT_REG_MASK) ||
                                  effective_address < dsac_pkg::DSAC_STACK_FLOOR);
        rd_word = denied ? dsac_pkg::DSAC_ZERO_WORD
                         : word_at({effective_address[15:1], 1'b0});
        rd_byte = effective_address[0] ? rd_word[15:8] : rd_word[7:0];

        if (req.valid)
        begin
            state_next.rsp.valid = 1'b1;
            state_next.rsp.addr_err = misalign;
            state_next.rsp.stack_err = stack_fault;
            state_next.rsp.access_denied = denied;
            case (req.op)
                dsac_pkg::DSAC_OP_READ:
                begin
                    if (req.amode == dsac_pkg::DSAC_AM_INDIRECT && req.post_inc)
                        state_next.default_working_reg[req.ptr] = ptr_val + step;
                    // A misaligned read still completes
                    if (req.byte_op)
                    begin
                        state_next.rsp.x_data = {dsac_pkg::DSAC_ZERO_BYTE, rd_byte};
                        state_next.default_working_reg[req.dst][7:0] = rd_byte;
                    end
                    else
                    begin
                        state_next.rsp.x_data = rd_word;
                        state_next.default_working_reg[req.dst] = rd_word;
                    end
                end
                dsac_pkg::DSAC_OP_WRITE:
                begin
                    if (req.amode == dsac_pkg::DSAC_AM_INDIRECT && req.post_inc)
                        state_next.default_working_reg[req.ptr] = ptr_val + step;
                    wr_data = req.byte_op ? {req.wdata[7:0], req.wdata[7:0]} : req.wdata;
                    wr_lanes = req.byte_op ? (effective_address[0] ? 2'b10 : 2'b01)
                                           : 2'b11;
                end
                dsac_pkg::DSAC_OP_PUSH:
                begin
                    wr_data = req.wdata;
                    wr_lanes = 2'b11;
                    state_next.default_working_reg[dsac_pkg::DSAC_SP_IDX] = sp_cur + dsac_pkg::DSAC_STEP_WORD;
                end
                dsac_pkg::DSAC_OP_CALL_PUSH:
                begin
                    wr_data = {dsac_pkg::DSAC_ZERO_BYTE, req.pc_high[7:0]};
                    wr_lanes = 2'b11;
                    state_next.default_working_reg[dsac_pkg::DSAC_SP_IDX] = sp_cur + dsac_pkg::DSAC_STEP_WORD;
                end
                dsac_pkg::DSAC_OP_EXC_PUSH:
                begin
                    wr_data = {req.status_low_byte, req.pc_high[7:0]};
                    wr_lanes = 2'b11;
                    state_next.default_working_reg[dsac_pkg::DSAC_SP_IDX] = sp_cur + dsac_pkg::DSAC_STEP_WORD;
                end
                dsac_pkg::DSAC_OP_POP:
                begin
                    state_next.default_working_reg[dsac_pkg::DSAC_SP_IDX] = effective_address;
                    state_next.rsp.x_data = rd_word;
                    state_next.default_working_reg[req.dst] = rd_word;
                end
                dsac_pkg::DSAC_OP_SIGN_EXT:
                begin
                    state_next.default_working_reg[req.dst] = {{8{dst_val[7]}}, dst_val[7:0]};
                    state_next.rsp.x_data = {{8{dst_val[7]}}, dst_val[7:0]};
                end
                dsac_pkg::DSAC_OP_ZERO_EXT:
                begin
                    state_next.default_working_reg[req.dst] = {dsac_pkg::DSAC_ZERO_BYTE, dst_val[7:0]};
                    state_next.rsp.x_data = {dsac_pkg::DSAC_ZERO_BYTE, dst_val[7:0]};
                end
                dsac_pkg::DSAC_OP_MAC_FETCH:
                begin
                    // Each pointer pair reads only its own space; the other gives zero
                    if (!in_range(effective_address, dsac_pkg::DSAC_Y_BASE,
                                  dsac_pkg::DSAC_Y_END) && !denied)
                        state_next.rsp.x_data = rd_word;
                    if (in_range(ea_y, dsac_pkg::DSAC_Y_BASE, dsac_pkg::DSAC_Y_END) &&
                        !sec_block(ea_y, req.exec_boot, req.exec_secure))
                        state_next.rsp.y_data = word_at(ea_y);
                    if (req.post_inc)
                    begin
                        state_next.default_working_reg[dsac_pkg::DSAC_MACX_IDX | 4'(req.mac_x_sel)] =
                            effective_address + dsac_pkg::DSAC_STEP_WORD;
                        state_next.default_working_reg[dsac_pkg::DSAC_MACY_IDX | 4'(req.mac_y_sel)] =
                            ea_y + dsac_pkg::DSAC_STEP_WORD;
                    end
                end
                default:
                begin
                    state_next.rsp.valid = 1'b1;
                end
            endcase
            // Write decode: a misaligned or refused write is dropped, the trap still raised
            if (misalign || denied)
                wr_lanes = 2'b00;
            wr_hit = default_working_reg_lookup(effective_address);
            if (wr_hit[4])
            begin
                if (wr_lanes[0])
                    state_next.default_working_reg[wr_hit[3:0]][7:0] = wr_data[7:0];
                if (wr_lanes[1])
                    state_next.default_working_reg[wr_hit[3:0]][15:8] = wr_data[15:8];
            end
            else if ({effective_address[15:1], 1'b0} == dsac_pkg::DSAC_STACK_LIMIT_REG_OFS)
            begin
                stack_limit_we = |wr_lanes;
                if (wr_lanes[0])
                    stack_limit_next[7:0] = wr_data[7:0];
                if (wr_lanes[1])
                    stack_limit_next[15:8] = wr_data[15:8];
                stack_limit_next = stack_limit_next & dsac_pkg::DSAC_STACK_LIMIT_REG_MASK;
            end
            else if (in_range(effective_address, dsac_pkg::DSAC_RAM_BASE,
                              dsac_pkg::DSAC_RAM_END))
            begin
                ram_we = wr_lanes;
                ram_idx = ram_index(effective_address);
                ram_wdata = wr_data;
            end
        end
    end

    // No reset on the limit register or the RAM
    always_ff @(posedge clk_sys)
    begin
        if (stack_limit_we)
            stack_limit_reg <= stack_limit_next;
        if (ram_we[0])
            ram_mem[ram_idx][7:0] <= ram_wdata[7:0];
        if (ram_we[1])
            ram_mem[ram_idx][15:8] <= ram_wdata[15:8];
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            state_reg <= dsac_pkg::DSAC_STATE_RESET;
        else
            state_reg <= state_next;
    end

    assign rsp = state_reg.rsp;

    sequence s_push_at_limit;
        req.valid && req.op == dsac_pkg::DSAC_OP_PUSH && sp_cur == stack_limit_reg &&
        sp_cur >= dsac_pkg::DSAC_STACK_FLOOR && sp_cur < dsac_pkg::DSAC_STACK_LIMIT_REG_MASK;
    endsequence

    sequence s_push;
        req.valid && req.op == dsac_pkg::DSAC_OP_PUSH;
    endsequence

    property p_misalign;
        @(posedge clk_sys) disable iff (!nrst)
        (req.valid && req.op == dsac_pkg::DSAC_OP_READ && !req.byte_op &&
         req.amode == dsac_pkg::DSAC_AM_ABS && req.abs_addr[0]) |=> rsp.addr_err;
    endproperty
    a_misalign: assert property (p_misalign) else $error("odd word read without trap");

    property p_misalign_write;
        @(posedge clk_sys) disable iff (!nrst)
        (req.valid && req.op == dsac_pkg::DSAC_OP_WRITE && misalign) |->
            (ram_we == 2'b00 && !stack_limit_we) ##1 rsp.addr_err;
    endproperty
    a_misalign_write: assert property (p_misalign_write) else $error("odd word write stored");

    property p_post_inc_byte;
        @(posedge clk_sys) disable iff (!nrst)
        (req.valid && req.op == dsac_pkg::DSAC_OP_READ && req.byte_op && req.post_inc &&
         req.amode == dsac_pkg::DSAC_AM_INDIRECT && req.dst != req.ptr) |=>
            state_reg.default_working_reg[$past(req.ptr)] == $past(ptr_val) + dsac_pkg::DSAC_STEP_BYTE;
    endproperty
    a_post_inc_byte: assert property (p_post_inc_byte) else $error("byte step not one");

    property p_push_step;
        @(posedge clk_sys) disable iff (!nrst)
        s_push |=> sp_cur == $past(sp_cur) + dsac_pkg::DSAC_STEP_WORD;
    endproperty
    a_push_step: assert property (p_push_step) else $error("push did not advance by two");

    property p_pop_step;
        @(posedge clk_sys) disable iff (!nrst)
        (req.valid && req.op == dsac_pkg::DSAC_OP_POP && req.dst != dsac_pkg::DSAC_SP_IDX) |=>
            sp_cur == $past(sp_cur) - dsac_pkg::DSAC_STEP_WORD;
    endproperty
    a_pop_step: assert property (p_pop_step) else $error("pop did not retreat by two");

    property p_limit_free;
        @(posedge clk_sys) disable iff (!nrst)
        s_push_at_limit |=> !rsp.stack_err;
    endproperty
    a_limit_free: assert property (p_limit_free) else $error("push at limit trapped");

    property p_limit_trap;
        @(posedge clk_sys) disable iff (!nrst)
        s_push_at_limit ##1 s_push |=> rsp.stack_err;
    endproperty
    a_limit_trap: assert property (p_limit_trap) else $error("push past limit not trapped");

    property p_underflow;
        @(posedge clk_sys) disable iff (!nrst)
        (req.valid && uses_sp && effective_address < dsac_pkg::DSAC_STACK_FLOOR) |=>
            rsp.stack_err && rsp.valid;
    endproperty
    a_underflow: assert property (p_underflow) else $error("stack underflow not trapped");

    property p_byte_read_low;
        @(posedge clk_sys) disable iff (!nrst)
        (req.valid && req.op == dsac_pkg::DSAC_OP_READ && req.byte_op) |=>
            rsp.x_data[15:8] == dsac_pkg::DSAC_ZERO_BYTE;
    endproperty
    a_byte_read_low: assert property (p_byte_read_low) else $error("byte not on low lane");

    property p_byte_load;
        @(posedge clk_sys) disable iff (!nrst)
        (req.valid && req.op == dsac_pkg::DSAC_OP_READ && req.byte_op && !req.post_inc) |=>
            state_reg.default_working_reg[$past(req.dst)][15:8] == $past(dst_val[15:8]);
    endproperty
    a_byte_load: assert property (p_byte_load) else $error("byte load changed upper byte");

    property p_sign_ext;
        @(posedge clk_sys) disable iff (!nrst)
        (req.valid && req.op == dsac_pkg::DSAC_OP_SIGN_EXT) |=>
            rsp.x_data[7:0] == $past(dst_val[7:0]) &&
            rsp.x_data[15:8] == {8{$past(dst_val[7])}};
    endproperty
    a_sign_ext: assert property (p_sign_ext) else $error("sign extension wrong");

    property p_call_push;
        @(posedge clk_sys) disable iff (!nrst)
        (req.valid && req.op == dsac_pkg::DSAC_OP_CALL_PUSH && ram_we != 2'b00) |->
            ram_wdata[15:8] == dsac_pkg::DSAC_ZERO_BYTE;
    endproperty
    a_call_push: assert property (p_call_push) else $error("call push upper byte not zero");

    property p_mac_y_zero;
        @(posedge clk_sys) disable iff (!nrst)
        (req.valid && req.op == dsac_pkg::DSAC_OP_MAC_FETCH &&
         !in_range(ea_y, dsac_pkg::DSAC_Y_BASE, dsac_pkg::DSAC_Y_END)) |=>
            rsp.y_data == dsac_pkg::DSAC_ZERO_WORD;
    endproperty
    a_mac_y_zero: assert property (p_mac_y_zero) else $error("wrong space fetch not zero");

endmodule

// file: tb/dsac_core_model.sv
// Core-side model that issues data space requests to the checker
`timescale 1ns/100ps
module dsac_core_model (
    input wire dsac_pkg::dsac_req_t req_in,
    output dsac_pkg::dsac_req_t req
);
    // Bench never reads through the stack pointer right after a limit write
    assign req = req_in;
endmodule

// file: tb/tb.sv
// Self-checking bench of the data space access checker
`timescale 1ns/100ps
module tb;
    logic clk_sys;
    logic nrst;
    logic bs_en;
    logic ss_en;
    dsac_pkg::dsac_req_t rq;
    dsac_pkg::dsac_req_t req;
    dsac_pkg::dsac_rsp_t rsp;
    dsac_pkg::dsac_rsp_t s;
    dsac_pkg::dsac_req_t q;
    int err_total = 0;
    int total_checks = 0;
    logic [15:0] d;
    logic [15:0] e;
    logic [15:0] pw [3];
    dsac_core_model u_dsac_core_model (.req_in(rq), .req(req));
    dsac_top u_dsac_top (.clk_sys(clk_sys), .nrst(nrst), .req(req),
        .boot_secure_ram_en(bs_en), .secure_segment_ram_en(ss_en), .rsp(rsp));
    initial
    begin
        clk_sys = 0;
        forever #25 clk_sys = ~clk_sys;
    end
    function automatic dsac_pkg::dsac_req_t mk(dsac_pkg::dsac_op_t o, logic [15:0] a,
        logic [15:0] w, logic b);
        mk = '0;
        mk.valid = 1'b1;
        mk.op = o;
        mk.amode = dsac_pkg::DSAC_AM_ABS;
        mk.abs_addr = a;
        mk.wdata = w;
        mk.byte_op = b;
        mk.dst = 4'h1;
        mk.ptr = 4'hF;
    endfunction
    function automatic logic [15:0] merge(logic [15:0] o, logic [7:0] b);
        merge = {b, o[7:0]};
    endfunction
    // Entered just after an edge; requests run back to back
    task automatic go(input dsac_pkg::dsac_req_t r);
        rq = r;
        @(posedge clk_sys);
        #1 s = rsp;
    endtask
    task automatic chk(input string n, input logic [15:0] v, input logic [15:0] x);
        total_checks++;
        if (v !== x)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, x, v);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        #200000;
        err_total++;
        tally_and_finish;
    end
    initial
    begin
        nrst = 0;
        rq = '0;
        bs_en = 0;
        ss_en = 0;
        s = '0;
        void'($urandom(38717));
        d = 16'($urandom);
        e = 16'($urandom);
        repeat (6) @(posedge clk_sys);
        #1 nrst = 1;
        go(mk(dsac_pkg::DSAC_OP_READ, 16'h0002, 16'h0000, 0));
        chk("reg1_reset", s.x_data, 16'h0000);
        go(mk(dsac_pkg::DSAC_OP_WRITE, 16'h0800, d, 0));
        go(mk(dsac_pkg::DSAC_OP_READ, 16'h0800, 16'h0000, 0));
        chk("word", s.x_data, d);
        go(mk(dsac_pkg::DSAC_OP_WRITE, 16'h0801, e, 1));
        go(mk(dsac_pkg::DSAC_OP_READ, 16'h0800, 16'h0000, 0));
        chk("byte_wr", s.x_data, merge(d, e[7:0]));
        go(mk(dsac_pkg::DSAC_OP_READ, 16'h0801, 16'h0000, 1));
        chk("byte_rd", {8'h00, s.x_data[7:0]}, {8'h00, e[7:0]});
        go(mk(dsac_pkg::DSAC_OP_WRITE, 16'h0802, d, 0));
        go(mk(dsac_pkg::DSAC_OP_WRITE, 16'h0803, ~d, 0));
        chk("mis_wr", {15'h0000, s.addr_err}, 16'h0001);
        go(mk(dsac_pkg::DSAC_OP_READ, 16'h0802, 16'h0000, 0));
        chk("wr_drop", s.x_data, d);
        go(mk(dsac_pkg::DSAC_OP_WRITE, 16'h0020, 16'h0803, 0));
        go(mk(dsac_pkg::DSAC_OP_READ, 16'h0020, 16'h0000, 0));
        chk("limit", s.x_data, 16'h0802);
        for (int i = 0; i < 3; i++)
        begin
            pw[i] = 16'($urandom);
            go(mk(dsac_pkg::DSAC_OP_PUSH, 16'h0000, pw[i], 0));
            chk("push_err", {15'h0000, s.stack_err}, {15'h0000, i == 2});
        end
        go(mk(dsac_pkg::DSAC_OP_READ, 16'h001E, 16'h0000, 0));
        chk("sp", s.x_data, 16'h0806);
        go(mk(dsac_pkg::DSAC_OP_POP, 16'h0000, 16'h0000, 0));
        chk("pop", s.x_data, pw[2]);
        go(mk(dsac_pkg::DSAC_OP_WRITE, 16'h001E, 16'h07FE, 0));
        go(mk(dsac_pkg::DSAC_OP_PUSH, 16'h0000, d, 0));
        chk("underflow", {15'h0000, s.stack_err}, 16'h0001);
        go(mk(dsac_pkg::DSAC_OP_READ, 16'h4000, 16'h0000, 0));
        chk("unimpl", s.x_data, 16'h0000);
        go(mk(dsac_pkg::DSAC_OP_READ, 16'h0805, 16'h0000, 0));
        chk("mis_rd", {15'h0000, s.addr_err}, 16'h0001);
        chk("mis_rd_data", s.x_data, pw[2]);
        chk("trap_split", {14'h0000, s.stack_err, s.valid}, 16'h0001);
        go(mk(dsac_pkg::DSAC_OP_WRITE, 16'h0004, 16'h0803, 0));
        q = mk(dsac_pkg::DSAC_OP_READ, 16'h0000, 16'h0000, 1);
        q.amode = dsac_pkg::DSAC_AM_INDIRECT;
        q.ptr = 4'h2;
        q.post_inc = 1'h1;
        go(q);
        chk("ind_byte", s.x_data, {8'h00, pw[1][15:8]});
        q.byte_op = 1'h0;
        q.dst = 4'h3;
        go(q);
        chk("ind_word", s.x_data, pw[2]);
        q = mk(dsac_pkg::DSAC_OP_READ, 16'hE002, 16'h0000, 0);
        q.amode = dsac_pkg::DSAC_AM_NEAR;
        go(q);
        chk("byte_load", s.x_data, {pw[2][15:8], pw[1][15:8]});
        go(mk(dsac_pkg::DSAC_OP_SIGN_EXT, 16'h0000, 16'h0000, 0));
        chk("sext", s.x_data, {{8{pw[1][15]}}, pw[1][15:8]});
        go(mk(dsac_pkg::DSAC_OP_ZERO_EXT, 16'h0000, 16'h0000, 0));
        chk("zext", s.x_data, {8'h00, pw[1][15:8]});
        go(mk(dsac_pkg::DSAC_OP_READ, 16'h0004, 16'h0000, 0));
        chk("post_inc", s.x_data, 16'h0806);
        q = mk(dsac_pkg::DSAC_OP_CALL_PUSH, 16'h0000, 16'h0000, 0);
        q.pc_high = d;
        q.status_low_byte = e[7:0];
        go(q);
        q.op = dsac_pkg::DSAC_OP_EXC_PUSH;
        go(q);
        go(mk(dsac_pkg::DSAC_OP_READ, 16'h0800, 16'h0000, 0));
        chk("call_push", s.x_data, {8'h00, d[7:0]});
        go(mk(dsac_pkg::DSAC_OP_READ, 16'h0802, 16'h0000, 0));
        chk("exc_push", s.x_data, {e[7:0], d[7:0]});
        go(mk(dsac_pkg::DSAC_OP_WRITE, 16'h0900, e, 0));
        go(mk(dsac_pkg::DSAC_OP_WRITE, 16'h0010, 16'h0900, 0));
        go(mk(dsac_pkg::DSAC_OP_WRITE, 16'h0012, 16'h0800, 0));
        go(mk(dsac_pkg::DSAC_OP_WRITE, 16'h0014, 16'h0900, 0));
        q = mk(dsac_pkg::DSAC_OP_MAC_FETCH, 16'h0000, 16'h0000, 0);
        go(q);
        chk("mac_x", s.x_data, 16'h0000);
        chk("mac_y", s.y_data, e);
        q.mac_x_sel = 1'h1;
        q.mac_y_sel = 1'h1;
        go(q);
        chk("mac_x_own", s.x_data, {8'h00, d[7:0]});
        chk("mac_y_zero", s.y_data, 16'h0000);
        bs_en = 1;
        ss_en = 1;
        go(mk(dsac_pkg::DSAC_OP_READ, 16'h0800, 16'h0000, 0));
        chk("boot_deny", {15'h0000, s.access_denied}, 16'h0001);
        go(mk(dsac_pkg::DSAC_OP_READ, 16'h0840, 16'h0000, 0));
        chk("sec_deny", {15'h0000, s.access_denied}, 16'h0001);
        tally_and_finish;
    end
endmodule
